// file: rtl/ugc_counter.sv
`timescale 1ns/1ps
`include "ugc_regs.svh"
module ugc_counter import ugc_pkg::*; #(
	parameter int NDIG   = 8,
	parameter int DIVW   = 24,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Comparator and event pins
	input  wire logic              a_above_hi,
	input  wire logic              a_below_lo,
	input  wire logic              b_above_hi,
	input  wire logic              b_below_lo,
	input  wire logic              start_in,
	input  wire logic              stop_in,
	// Outputs
	output logic                   gate_open,
	output logic                   scale_out
);

	// ==========================================================
	// Helpers
	function automatic logic [DIVW-1:0] pow10(input logic [2:0] e);
		logic [DIVW-1:0] p;
		p = DIVW'(1);
		for (int i = 0; i < 7; i++) begin
			if (i < int'(e)) begin
				p = p * DIVW'(10);
			end
		end
		return p;
	endfunction

	function automatic logic [NDIG*4:0] bcd_inc(input logic [NDIG*4-1:0] v);
		logic [NDIG*4-1:0] r;
		logic              c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < NDIG; i++) begin
			if (c) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return {c, r};
	endfunction

	// ==========================================================
	// Conditioned inputs
	ugc_evt_if ev_a ();
	ugc_evt_if ev_b ();
	ugc_evt_if ev_start ();
	ugc_evt_if ev_stop ();

	ugc_event_detect u_det_a (.aclk(aclk), .aresetn(aresetn),
		.above_hi(a_above_hi), .below_lo(a_below_lo), .evt(ev_a));
	ugc_event_detect u_det_b (.aclk(aclk), .aresetn(aresetn),
		.above_hi(b_above_hi), .below_lo(b_below_lo), .evt(ev_b));
	// Edge inputs reuse the detector: one pulse per rising edge
	ugc_event_detect u_det_start (.aclk(aclk), .aresetn(aresetn),
		.above_hi(start_in), .below_lo(!start_in), .evt(ev_start));
	ugc_event_detect u_det_stop (.aclk(aclk), .aresetn(aresetn),
		.above_hi(stop_in), .below_lo(!stop_in), .evt(ev_stop));

	// ==========================================================
	// Register bus state
	logic [ADDR_W-1:0] aw_q, aw_d;
	logic              awv_q, awv_d, wv_q, wv_d;
	logic [31:0]       wd_q, wd_d;
	logic [3:0]        ws_q, ws_d;
	logic              awready_q, awready_d, wready_q, wready_d;
	logic              bvalid_q, bvalid_d, arready_q, arready_d;
	logic              rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]       rdata_q, rdata_d, ctrl_q, ctrl_d;
	logic              start_q, start_d, abort_q, abort_d;
	logic              dclr_q, dclr_d;

	// Measurement state
	ugc_state_type     state_q, state_d;
	logic              gate_q, gate_d, done_q, done_d, ovf_q, ovf_d;
	logic              scale_q, scale_d;
	logic [6:0]        tb_cnt_q, tb_cnt_d;
	logic [3:0]        us_cnt_q, us_cnt_d;
	logic [DIVW-1:0]   dv_cnt_q, dv_cnt_d, ad_cnt_q, ad_cnt_d;
	logic [NDIG*4-1:0] digits_q, digits_d, result_q, result_d;

	logic [2:0]        mode_f, gexp_f, aexp_f;
	logic [1:0]        tbsel_f;
	logic [6:0]        tb_lim;
	logic [3:0]        us_lim;
	logic              tb_tick, us_tick, dv_pulse, ad_pulse;
	logic              open_ev, close_ev, cnt_ev;
	logic [NDIG*4:0]   inc;

	assign mode_f  = ctrl_q[`UGC_CTRL_MODE_LSB +: 3];
	assign gexp_f  = ctrl_q[`UGC_CTRL_GEXP_LSB +: 3];
	assign aexp_f  = ctrl_q[`UGC_CTRL_AEXP_LSB +: 3];
	assign tbsel_f = ctrl_q[`UGC_CTRL_TBSEL_LSB +: 2];

	// ==========================================================
	// AXI4-Lite slave
	always_comb begin
		aw_d = aw_q;
		awv_d = awv_q;
		wd_d = wd_q;
		ws_d = ws_q;
		wv_d = wv_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		start_d = 1'b0;
		abort_d = 1'b0;
		dclr_d = 1'b0;
		if (s_axi_awvalid && awready_q) begin
			aw_d = s_axi_awaddr;
			awv_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q) begin
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
			wv_d = 1'b1;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (awv_q && wv_q && !bvalid_q) begin
			awv_d = 1'b0;
			wv_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `UGC_RESP_OKAY;
			unique case (aw_q)
				`UGC_OFS_CTRL: begin
					for (int i = 0; i < 4; i++) begin
						if (ws_q[i]) begin
							ctrl_d[i*8 +: 8] = wd_q[i*8 +: 8];
						end
					end
				end
				`UGC_OFS_CMD: begin
					start_d = ws_q[0] && wd_q[`UGC_CMD_START_BIT];
					abort_d = ws_q[0] && wd_q[`UGC_CMD_ABORT_BIT];
				end
				`UGC_OFS_STATUS: begin
					dclr_d = ws_q[0] && wd_q[`UGC_STAT_DONE_BIT];
				end
				`UGC_OFS_RESULT: ;
				default: bresp_d = `UGC_RESP_SLVERR;
			endcase
		end
		awready_d = !awv_d && !bvalid_d;
		wready_d = !wv_d && !bvalid_d;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = `UGC_RESP_OKAY;
			rdata_d = 32'h0;
			unique case (s_axi_araddr)
				`UGC_OFS_CTRL:   rdata_d = ctrl_q;
				`UGC_OFS_CMD:    rdata_d = 32'h0;
				`UGC_OFS_STATUS: rdata_d = {28'h0, ovf_q, gate_q,
					done_q, state_q != ST_IDLE};
				`UGC_OFS_RESULT: rdata_d = 32'(result_q);
				default:         rresp_d = `UGC_RESP_SLVERR;
			endcase
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= '0;
			awv_q <= 1'b0;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			wv_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0;
			ctrl_q <= `UGC_CTRL_RESET;
			start_q <= 1'b0;
			abort_q <= 1'b0;
			dclr_q <= 1'b0;
		end else begin
			aw_q <= aw_d;
			awv_q <= awv_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			wv_q <= wv_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			start_q <= start_d;
			abort_q <= abort_d;
			dclr_q <= dclr_d;
		end
	end

	// ==========================================================
	// Time base, decade dividers and gate sequence
	always_comb begin
		unique case (tbsel_f)
			`UGC_TB_SEL_1MHZ: begin
				tb_lim = 7'(`UGC_ACLK_MHZ / `UGC_TB_1MHZ);
				us_lim = 4'(`UGC_TB_1MHZ);
			end
			`UGC_TB_SEL_5MHZ: begin
				tb_lim = 7'(`UGC_ACLK_MHZ / `UGC_TB_5MHZ);
				us_lim = 4'(`UGC_TB_5MHZ);
			end
			default: begin
				tb_lim = 7'(`UGC_ACLK_MHZ / `UGC_TB_10MHZ);
				us_lim = 4'(`UGC_TB_10MHZ);
			end
		endcase
		tb_tick = tb_cnt_q >= tb_lim - 7'h01;
		// Normalise to a 1 us tick so gate length ignores the rate
		us_tick = tb_tick && us_cnt_q >= us_lim - 4'h1;
		dv_pulse = us_tick && dv_cnt_q >= pow10(gexp_f) - DIVW'(1);
		ad_pulse = ev_a.pulse
			&& ad_cnt_q >= pow10(aexp_f) - DIVW'(1);
		tb_cnt_d = tb_tick ? 7'h00 : tb_cnt_q + 7'h01;
		us_cnt_d = us_cnt_q;
		if (tb_tick) begin
			us_cnt_d = us_tick ? 4'h0 : us_cnt_q + 4'h1;
		end
		dv_cnt_d = dv_cnt_q;
		if (us_tick) begin
			dv_cnt_d = dv_pulse ? DIVW'(0) : dv_cnt_q + DIVW'(1);
		end
		ad_cnt_d = ad_cnt_q;
		if (ev_a.pulse) begin
			ad_cnt_d = ad_pulse ? DIVW'(0) : ad_cnt_q + DIVW'(1);
		end
		// A new setting restarts both dividers, so a shorter gate never
		// meets a count already past its end; rewriting it mid-gate
		// therefore stretches that gate
		if (ctrl_d != ctrl_q) begin
			dv_cnt_d = DIVW'(0);
			ad_cnt_d = DIVW'(0);
		end
		open_ev = 1'b0;
		close_ev = 1'b0;
		cnt_ev = 1'b0;
		unique case (mode_f)
			M_FREQ: begin
				open_ev = dv_pulse;
				close_ev = dv_pulse;
				cnt_ev = ev_a.pulse;
			end
			M_PERIOD: begin
				open_ev = ad_pulse;
				close_ev = ad_pulse;
				cnt_ev = dv_pulse;
			end
			M_RATIO: begin
				open_ev = ad_pulse;
				close_ev = ad_pulse;
				cnt_ev = ev_b.pulse;
			end
			M_TINT: begin
				open_ev = ev_start.pulse;
				close_ev = ev_stop.pulse;
				cnt_ev = dv_pulse;
			end
			default: ;
		endcase
		scale_d = (mode_f == M_SCALE) && ad_pulse;
		state_d = state_q;
		gate_d = gate_q;
		digits_d = digits_q;
		result_d = result_q;
		ovf_d = ovf_q;
		done_d = done_q && !dclr_q;
		inc = bcd_inc(digits_q);
		// Events in the closing cycle still count; the opening one not
		if (gate_q && cnt_ev) begin
			digits_d = inc[NDIG*4-1:0];
			ovf_d = ovf_q || inc[NDIG*4];
		end
		unique case (state_q)
			ST_IDLE: begin
				if (start_q && mode_f != M_SCALE) begin
					digits_d = '0;
					ovf_d = 1'b0;
					done_d = 1'b0;
					state_d = ST_ARM;
				end
			end
			ST_ARM: begin
				if (open_ev) begin
					gate_d = 1'b1;
					state_d = ST_OPEN;
				end
			end
			ST_OPEN: begin
				if (close_ev) begin
					gate_d = 1'b0;
					result_d = digits_d;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
		endcase
		if (abort_q) begin
			// An abort that meets the close leaves the old result
			gate_d = 1'b0;
			result_d = result_q;
			done_d = done_q && !dclr_q;
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			gate_q <= 1'b0;
			done_q <= 1'b0;
			ovf_q <= 1'b0;
			scale_q <= 1'b0;
			tb_cnt_q <= 7'h00;
			us_cnt_q <= 4'h0;
			dv_cnt_q <= '0;
			ad_cnt_q <= '0;
			digits_q <= '0;
			result_q <= '0;
		end else begin
			state_q <= state_d;
			gate_q <= gate_d;
			done_q <= done_d;
			ovf_q <= ovf_d;
			scale_q <= scale_d;
			tb_cnt_q <= tb_cnt_d;
			us_cnt_q <= us_cnt_d;
			dv_cnt_q <= dv_cnt_d;
			ad_cnt_q <= ad_cnt_d;
			digits_q <= digits_d;
			result_q <= result_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign gate_open     = gate_q;
	assign scale_out     = scale_q;

	// ==========================================================
	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence freq_open_s;
		mode_f == M_FREQ && state_q == ST_ARM && dv_pulse && !abort_q;
	endsequence

	sequence ti_stop_s;
		mode_f == M_TINT && state_q == ST_OPEN && ev_stop.pulse && !abort_q;
	endsequence

	tb_tick_rate_a: assert property (
		tb_tick |=> !tb_tick [*8])
		else $error("time base tick faster than 10 MHz");

	divider_period_a: assert property (
		dv_pulse |-> us_tick && dv_cnt_q == pow10(gexp_f) - DIVW'(1))
		else $error("divider pulse at wrong count");

	gate_block_a: assert property (
		!gate_q && !start_q |=> digits_q == $past(digits_q))
		else $error("closed gate let a count through");

	gate_pass_a: assert property (
		gate_q && cnt_ev && state_q == ST_OPEN
		|=> digits_q != $past(digits_q))
		else $error("open gate lost a count");

	freq_toggle_a: assert property (
		freq_open_s |=> gate_q && state_q == ST_OPEN)
		else $error("divider pulse did not open gate");

	result_hold_a: assert property (
		result_q != $past(result_q) |-> $past(gate_q) && !gate_q && done_q)
		else $error("result changed while gate open");

	clear_before_a: assert property (
		state_q == ST_ARM |-> digits_q == '0 && !gate_q)
		else $error("stages not cleared before gate");

	ti_close_a: assert property (
		ti_stop_s |=> !gate_q ##1 !gate_q)
		else $error("stop edge did not close gate");

	scale_follow_a: assert property (
		mode_f == M_SCALE && ad_pulse |=> scale_out ##1 !scale_out)
		else $error("scaled output not coherent");

endmodule

// file: rtl/ugc_regs.svh
`ifndef UGC_REGS_SVH
`define UGC_REGS_SVH

// ==========================================================
// Clock and time base
`define UGC_ACLK_MHZ        100
`define UGC_TB_1MHZ         1
`define UGC_TB_5MHZ         5
`define UGC_TB_10MHZ        10
`define UGC_TB_SEL_1MHZ     2'h0
`define UGC_TB_SEL_5MHZ     2'h1
`define UGC_TB_SEL_10MHZ    2'h2

// ==========================================================
// Register offsets
`define UGC_OFS_CTRL        8'h00
`define UGC_OFS_CMD         8'h04
`define UGC_OFS_STATUS      8'h08
`define UGC_OFS_RESULT      8'h0c

// ==========================================================
// Field positions
`define UGC_CTRL_MODE_LSB   0
`define UGC_CTRL_GEXP_LSB   4
`define UGC_CTRL_AEXP_LSB   8
`define UGC_CTRL_TBSEL_LSB  12
`define UGC_CMD_START_BIT   0
`define UGC_CMD_ABORT_BIT   1
`define UGC_STAT_BUSY_BIT   0
`define UGC_STAT_DONE_BIT   1
`define UGC_STAT_GATE_BIT   2
`define UGC_STAT_OVF_BIT    3

// ==========================================================
// Reset values and responses
`define UGC_CTRL_RESET      32'h0000_2060
`define UGC_RESP_OKAY       2'h0
`define UGC_RESP_SLVERR     2'h2

`endif

// file: rtl/ugc_pkg.sv
package ugc_pkg;

	// ==========================================================
	// Measurement modes, as held in the mode field
	typedef enum logic [2:0] {
		M_FREQ,
		M_PERIOD,
		M_RATIO,
		M_TINT,
		M_SCALE
	} ugc_mode_type;

	// ==========================================================
	// Measurement sequence
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARM,
		ST_OPEN
	} ugc_state_type;

endpackage

// file: rtl/ugc_evt_if.sv
`timescale 1ns/1ps
interface ugc_evt_if;
	logic pulse;
	logic armed;
	modport src (output pulse, output armed);
	modport snk (input pulse, input armed);
endinterface

// file: rtl/ugc_event_detect.sv
`timescale 1ns/1ps
module ugc_event_detect (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Threshold comparator levels from the pins
	input  wire logic above_hi,
	input  wire logic below_lo,
	// Conditioned events
	ugc_evt_if.src    evt
);

	logic hi_meta_q, hi_s_q, lo_meta_q, lo_s_q;
	logic armed_q, armed_d;
	logic pulse_q, pulse_d;

	// ==========================================================
	// Hysteresis: arm on the low crossing, fire on the high one
	always_comb begin
		armed_d = armed_q;
		pulse_d = 1'b0;
		if (lo_s_q) begin
			armed_d = 1'b1;
		end else if (hi_s_q) begin
			pulse_d = armed_q;
			armed_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_meta_q <= 1'b0;
			hi_s_q    <= 1'b0;
			lo_meta_q <= 1'b0;
			lo_s_q    <= 1'b0;
			armed_q   <= 1'b0;
			pulse_q   <= 1'b0;
		end else begin
			hi_meta_q <= above_hi;
			hi_s_q    <= hi_meta_q;
			lo_meta_q <= below_lo;
			lo_s_q    <= lo_meta_q;
			armed_q   <= armed_d;
			pulse_q   <= pulse_d;
		end
	end

	assign evt.pulse = pulse_q;
	assign evt.armed = armed_q;

	// ==========================================================
	// Checks
	one_pulse_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		pulse_q |=> !pulse_q ##1 !pulse_q)
		else $error("event pulse longer than one cycle");

	both_levels_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		pulse_q |-> $past(armed_q) && !armed_q)
		else $error("event without prior low crossing");

endmodule

// file: tb/ugc_source_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side signal sources for the two comparator channels
module ugc_source_model (
	// Clock
	input  wire logic       aclk,
	// Channel A control
	input  wire logic       run_a,
	input  wire logic       ring_a,
	input  wire logic [7:0] half_a,
	// Channel B control
	input  wire logic       run_b,
	input  wire logic [7:0] half_b,
	// Comparator levels
	output logic            a_above_hi,
	output logic            a_below_lo,
	output logic            b_above_hi,
	output logic            b_below_lo
);
	logic [7:0] cnt_a_q = 8'h0;
	logic [7:0] cnt_b_q = 8'h0;
	logic       ph_a_q  = 1'b0;
	logic       ph_b_q  = 1'b0;

	// Square waves, half periods counted in aclk cycles
	always @(posedge aclk) begin
		if (run_a) begin
			cnt_a_q <= (cnt_a_q >= half_a - 8'h1) ? 8'h0 : cnt_a_q + 8'h1;
			if (cnt_a_q >= half_a - 8'h1)
				ph_a_q <= ~ph_a_q;
		end
		if (run_b) begin
			cnt_b_q <= (cnt_b_q >= half_b - 8'h1) ? 8'h0 : cnt_b_q + 8'h1;
			if (cnt_b_q >= half_b - 8'h1)
				ph_b_q <= ~ph_b_q;
		end
	end

	// Stopped sources sit between the thresholds; ringing never
	// reaches the lower one, so it should produce no count
	assign a_above_hi = run_a & ph_a_q;
	assign a_below_lo = run_a & ~ring_a & ~ph_a_q;
	assign b_above_hi = run_b & ph_b_q;
	assign b_below_lo = run_b & ~ph_b_q;
endmodule

// file: tb/universal_gated_counter_test.sv
`timescale 1ns/1ps
`include "ugc_regs.svh"
module universal_gated_counter_test import ugc_pkg::*;;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0, half_a = 8'h5, half_b = 8'h5;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, gate_open, scale_out;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, d, prev;
	logic [1:0]  r;
	logic        a_hi, a_lo, b_hi, b_lo;
	logic        start_in = 0, stop_in = 0;
	logic        run_a = 0, ring_a = 0, run_b = 0;
	int          fail_count = 0, samples_checked = 0, t;
	logic [31:0] glen = 0, last_len = 0, scnt = 0, s0;

	initial begin
		forever #5 aclk = ~aclk;
	end

	ugc_counter u_ugc_counter (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .a_above_hi(a_hi),
		.a_below_lo(a_lo), .b_above_hi(b_hi), .b_below_lo(b_lo),
		.start_in(start_in), .stop_in(stop_in), .gate_open(gate_open),
		.scale_out(scale_out));

	ugc_source_model u_ugc_source_model (.aclk(aclk), .run_a(run_a),
		.ring_a(ring_a), .half_a(half_a), .run_b(run_b), .half_b(half_b),
		.a_above_hi(a_hi), .a_below_lo(a_lo), .b_above_hi(b_hi),
		.b_below_lo(b_lo));

	// ==========================================================
	// Gate length and scaled output monitors
	always @(posedge aclk) begin
		if (gate_open === 1'b1)
			glen <= glen + 1;
		else begin
			if (glen != 0)
				last_len <= glen;
			glen <= 0;
		end
		if (scale_out === 1'b1)
			scnt <= scnt + 1;
	end

	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rsp);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (bvalid !== 1'b1 && n < 1000);
		rsp = bresp;
		bready <= 0;
		if (n >= 1000) fail_count++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rsp);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 0;
		end while (rvalid !== 1'b1 && n < 1000);
		v = rdata;
		rsp = rresp;
		rready <= 0;
		if (n >= 1000) fail_count++;
	endtask

	// ==========================================================
	// Compare and measurement helpers
	task automatic chk(input string nm, input logic [31:0] lo, hi, got);
		samples_checked++;
		if ($isunknown(got) || got < lo || got > hi) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d",
				nm, lo, hi, got);
		end
	endtask

	function automatic logic [31:0] bcd2bin(input logic [31:0] w);
		logic [31:0] v;
		v = 0;
		for (int i = 7; i >= 0; i--) v = v * 10 + w[i*4+:4];
		return v;
	endfunction

	function automatic logic [31:0] ctl(input ugc_mode_type md,
		input int n, m, tb);
		return 32'(md) | (32'(n) << `UGC_CTRL_GEXP_LSB)
			| (32'(m) << `UGC_CTRL_AEXP_LSB) | (32'(tb) << `UGC_CTRL_TBSEL_LSB);
	endfunction

	task automatic begin_meas(input logic [31:0] c);
		logic [1:0] rsp;
		wr(`UGC_OFS_CTRL, c, rsp);
		wr(`UGC_OFS_CMD, 32'h1, rsp);
	endtask

	// Waits for done, checks the total, then clears done
	task automatic end_meas(input string nm, input logic [31:0] lo, hi);
		logic [31:0] v;
		logic [1:0]  rsp;
		int          n;
		v = 0;
		n = 0;
		while (v[`UGC_STAT_DONE_BIT] !== 1'b1 && n < 2000) begin
			rd(`UGC_OFS_STATUS, v, rsp);
			n++;
		end
		chk({nm, " done"}, 1, 1, 32'(v[`UGC_STAT_DONE_BIT]));
		rd(`UGC_OFS_RESULT, v, rsp);
		prev = bcd2bin(v);
		chk(nm, lo, hi, prev);
		wr(`UGC_OFS_STATUS, 32'h2, rsp);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rd(`UGC_OFS_CTRL, d, r);
		chk("ctrl reset", `UGC_CTRL_RESET, `UGC_CTRL_RESET, d);
		rd(`UGC_OFS_STATUS, d, r);
		chk("status reset", 0, 0, d);
		rd(8'h10, d, r);
		chk("unmapped rresp", 2, 2, 32'(r));
		chk("unmapped rdata", 0, 0, d);
		wr(8'h14, 32'h1, r);
		chk("unmapped bresp", 2, 2, 32'(r));
		// A period 10 cycles: ten events in each 1 us gate
		run_a <= 1;
		for (t = 0; t < 3; t++) begin
			begin_meas(ctl(M_FREQ, 0, 0, t));
			end_meas("freq total", 9, 11);
			chk("gate length", 99, 101, last_len);
		end
		begin_meas(ctl(M_FREQ, 1, 0, 2));
		end_meas("freq 10us total", 99, 101);
		chk("gate length 10us", 999, 1001, last_len);
		repeat (200) @(posedge aclk);
		rd(`UGC_OFS_RESULT, d, r);
		chk("result holds", prev, prev, bcd2bin(d));
		// Ringing after a full count: cleared stages, nothing counted
		ring_a <= 1;
		// Let the crossing still armed from the last low pass first
		repeat (20) @(posedge aclk);
		begin_meas(ctl(M_FREQ, 0, 0, 2));
		end_meas("ringing total", 0, 0);
		ring_a <= 0;
		half_a <= 8'd100;
		begin_meas(ctl(M_PERIOD, 0, 0, 2));
		end_meas("period total", 1, 3);
		begin_meas(ctl(M_PERIOD, 0, 1, 2));
		end_meas("average total", 19, 21);
		run_b <= 1;
		begin_meas(ctl(M_RATIO, 0, 0, 2));
		end_meas("ratio total", 19, 21);
		// Start and stop 500 cycles apart: five 1 us pulses
		begin_meas(ctl(M_TINT, 0, 0, 2));
		repeat (20) @(posedge aclk);
		start_in <= 1;
		repeat (500) @(posedge aclk);
		stop_in <= 1;
		end_meas("interval total", 4, 6);
		start_in <= 0;
		stop_in <= 0;
		half_a <= 8'd5;
		wr(`UGC_OFS_CTRL, ctl(M_SCALE, 0, 1, 2), r);
		s0 = scnt;
		repeat (1000) @(posedge aclk);
		chk("scaled pulses", 9, 11, scnt - s0);
		// Abort while armed, before the gate opens, leaves nothing busy, done or open
		begin_meas(ctl(M_FREQ, 1, 0, 2));
		repeat (300) @(posedge aclk);
		rd(`UGC_OFS_STATUS, d, r);
		chk("busy bit", 1, 1, 32'(d[`UGC_STAT_BUSY_BIT]));
		wr(`UGC_OFS_CMD, 32'h2, r);
		rd(`UGC_OFS_STATUS, d, r);
		chk("status after abort", 0, 0, d & 32'h7);
		// A start without the low byte strobe must be ignored
		wstrb <= 4'he;
		wr(`UGC_OFS_CMD, 32'h1, r);
		wstrb <= 4'hf;
		rd(`UGC_OFS_STATUS, d, r);
		chk("start without strobe", 0, 0, d & 32'h7);
		close_out;
	end

	// Expected run is about 100 us
	initial begin
		#500us;
		fail_count++;
		close_out;
	end
endmodule
